// ---- loop_consts.svh ----
// Overview of operation
// [R01] Connection loop returns a tributary's TDM bus traffic to its source.
// [R02] Connection loop on a routed tributary sends AIS toward the routed interface.
// [R03] Line loop returns line input to the line, sends AIS onto the bus.
// [R04] Local loop returns bus input to the bus, sends AIS to the line.
// [R05] Modem receive loop returns selected E1 group; high-speed bus passes unchanged.
// [R06] Ethernet traffic looped by an IF or RF radio loop is discarded.
// [R07] Link remote loopback accepted on LAN interfaces only, else refused.
// [R08] Matching frames get MAC addresses swapped and leave by the ingress port.
// [R09] Match on ingress port, egress port, VLAN, source and destination MAC.
// [R10] Address swap keeps full line rate without dropping matching frames.
// [R11] Without destination filter, all frames loop; source becomes own switch MAC.
// [R12] Egress-lookup: frames bound for the configured egress port loop back instead.
// [R13] Software enables egress-lookup only for learned, up, VLAN-member egress port.
// [R14] Only one swap session per node; a second start request is rejected.
// [R15] Active session ends automatically after its timeout, which resets to 300 s.
// [R16] Tributary AIS is continuous all-ones while the loop stays active.
// [R17] One tributary loop at a time; a new request replaces the old.
`ifndef LOOP_CONSTS_SVH
`define LOOP_CONSTS_SVH
// ==========================================================
// Register map (byte offsets)
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_PORTS 8'h08
`define REG_DA_LO 8'h0c
`define REG_DA_HI 8'h10
`define REG_SA_LO 8'h14
`define REG_SA_HI 8'h18
`define REG_OWN_LO 8'h1c
`define REG_OWN_HI 8'h20
`define REG_TIMEOUT 8'h24
`define REG_REMAIN 8'h28
`define REG_TRIB_LOOP 8'h2c
`define REG_RX_LOOP 8'h30
`define REG_ROUTED 8'h34
`define REG_LOOPED_CNT 8'h38
// ==========================================================
// Field positions
`define CTRL_START 0
`define CTRL_STOP 1
`define CTRL_DA_FILT 2
`define CTRL_SA_FILT 3
`define CTRL_EGR_LKP 4
`define ST_ACTIVE 0
`define ST_REJECT 1
`define ST_TIMEOUT 2
`define ST_LRL_ACTIVE 3
`define PORTS_IN_LSB 0
`define PORTS_EG_LSB 8
`define PORTS_VID_LSB 16
// ==========================================================
// Reset values and frame constants
`define TIMEOUT_RST_S 16'h012c
`define CTRL_RST 5'h04
`define VLAN_TPID 16'h8100
// ==========================================================
// Timing
`define CLK_PERIOD_NS 20
`define NS_PER_S 1000000000
`define SEC_TICKS (`NS_PER_S / `CLK_PERIOD_NS)
`endif

// ---- loop_pkg.sv ----
package loop_pkg;
  // Per-tributary loop selection, one code holds at most one loop
  typedef enum logic [1:0] {LOOP_NONE, LOOP_CONN, LOOP_LINE, LOOP_LOCAL} trib_loop_t;
  // MAC-swap session state
  typedef enum logic {SES_IDLE, SES_ACTIVE} sess_state_t;
endpackage

// ---- swap_if.sv ----
`timescale 1ns/10ps
interface swap_if;
  logic active;
  logic da_filt;
  logic sa_filt;
  logic egr_lkp;
  logic [7:0] in_port;
  logic [7:0] eg_port;
  logic [11:0] vid;
  logic [47:0] da;
  logic [47:0] sa;
  logic [47:0] own_mac;
  logic radio_loop;
  logic [7:0] radio_port;
  logic looped;
  modport ctrl (output active, da_filt, sa_filt, egr_lkp, in_port, eg_port, vid, da, sa,
    own_mac, radio_loop, radio_port, input looped);
  modport swapper (input active, da_filt, sa_filt, egr_lkp, in_port, eg_port, vid, da, sa,
    own_mac, radio_loop, radio_port, output looped);
endinterface

// ---- mac_swap.sv ----
`timescale 1ns/10ps
`include "loop_consts.svh"
module mac_swap #(
  parameter int DW = 256
)(
  input wire logic pclk,
  input wire logic presetn,
  swap_if.swapper cfg,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic in_sop,
  input wire logic in_eop,
  input wire logic [DW-1:0] in_data,
  input wire logic [7:0] in_port,
  input wire logic [7:0] in_lkp_port,
  output logic out_valid,
  input wire logic out_ready,
  output logic out_sop,
  output logic out_eop,
  output logic out_loop,
  output logic [7:0] out_port,
  output logic [DW-1:0] out_data
);
  initial begin
    if (DW < 128) $error("DW must hold a full tagged header in one beat");
  end
  // ==========================================================
  // Header fields of the first beat
  logic [47:0] hdr_da;
  logic [47:0] hdr_sa;
  logic [15:0] hdr_tpid;
  logic [11:0] hdr_vid;
  logic match;
  logic drop_sop;
  logic accept;
  logic cur_loop;
  logic cur_drop;
  logic [DW-1:0] swapped;
  logic hold_loop_r, hold_loop_nxt;
  logic hold_drop_r, hold_drop_nxt;
  logic out_valid_r, out_valid_nxt;
  logic out_sop_r, out_sop_nxt;
  logic out_eop_r, out_eop_nxt;
  logic out_loop_r, out_loop_nxt;
  logic [7:0] out_port_r, out_port_nxt;
  logic [DW-1:0] out_data_r, out_data_nxt;
  logic looped_r, looped_nxt;

  assign hdr_da = in_data[DW-1 -: 48];
  assign hdr_sa = in_data[DW-49 -: 48];
  assign hdr_tpid = in_data[DW-97 -: 16];
  assign hdr_vid = in_data[DW-117 -: 12];
  // Frame selection; egress port only counts in egress-lookup mode
  assign match = cfg.active && (in_port == cfg.in_port) && (hdr_tpid == `VLAN_TPID) &&
    (hdr_vid == cfg.vid) && (!cfg.sa_filt || hdr_sa == cfg.sa) &&
    (!cfg.da_filt || hdr_da == cfg.da) &&
    (!cfg.egr_lkp || in_lkp_port == cfg.eg_port); // R09 R12 R13 R11
  assign drop_sop = cfg.radio_loop && (in_port == cfg.radio_port); // R06
  // DA takes the old SA; SA takes old DA or the switch's own address
  assign swapped = {hdr_sa, (cfg.da_filt ? hdr_da : cfg.own_mac), in_data[DW-97:0]}; // R08 R11
  // One beat per cycle unless downstream stalls
  assign in_ready = !out_valid_r || out_ready; // R10
  assign accept = in_valid && in_ready;
  assign cur_loop = in_sop ? match : hold_loop_r;
  assign cur_drop = in_sop ? drop_sop : hold_drop_r;

  // ==========================================================
  // Output stage next values
  always_comb begin
    hold_loop_nxt = hold_loop_r;
    hold_drop_nxt = hold_drop_r;
    out_valid_nxt = out_valid_r;
    out_sop_nxt = out_sop_r;
    out_eop_nxt = out_eop_r;
    out_loop_nxt = out_loop_r;
    out_port_nxt = out_port_r;
    out_data_nxt = out_data_r;
    looped_nxt = 1'b0;
    if (accept) begin
      hold_loop_nxt = cur_loop;
      hold_drop_nxt = cur_drop;
      out_valid_nxt = !cur_drop; // R06
      out_sop_nxt = in_sop;
      out_eop_nxt = in_eop;
      out_loop_nxt = cur_loop;
      out_port_nxt = cur_loop ? in_port : in_lkp_port; // R08 R12
      out_data_nxt = (in_sop && match) ? swapped : in_data; // R08
      looped_nxt = in_sop && match && !drop_sop;
    end else if (out_ready) begin
      out_valid_nxt = 1'b0;
    end
  end

  // Output stage registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_loop_r <= 1'b0;
      hold_drop_r <= 1'b0;
      out_valid_r <= 1'b0;
      out_sop_r <= 1'b0;
      out_eop_r <= 1'b0;
      out_loop_r <= 1'b0;
      out_port_r <= 8'h00;
      out_data_r <= '0;
      looped_r <= 1'b0;
    end else begin
      hold_loop_r <= hold_loop_nxt;
      hold_drop_r <= hold_drop_nxt;
      out_valid_r <= out_valid_nxt;
      out_sop_r <= out_sop_nxt;
      out_eop_r <= out_eop_nxt;
      out_loop_r <= out_loop_nxt;
      out_port_r <= out_port_nxt;
      out_data_r <= out_data_nxt;
      looped_r <= looped_nxt;
    end
  end

  assign out_valid = out_valid_r;
  assign out_sop = out_sop_r;
  assign out_eop = out_eop_r;
  assign out_loop = out_loop_r;
  assign out_port = out_port_r;
  assign out_data = out_data_r;
  assign cfg.looped = looped_r;

  // ==========================================================
  // Checks
  a_swap_addr: assert property (@(posedge pclk) disable iff (!presetn) // R08
    accept && in_sop && match |=> out_data_r[DW-1 -: 48] == $past(hdr_sa) && out_loop_r
    && out_port_r == $past(in_port))
    else $error("looped frame lacks swapped DA or ingress port");
  a_own_sa: assert property (@(posedge pclk) disable iff (!presetn) // R11
    accept && in_sop && match && !cfg.da_filt |=> out_data_r[DW-49 -: 48] == $past(cfg.own_mac))
    else $error("unfiltered loop did not use own MAC as SA");
  a_radio_drop: assert property (@(posedge pclk) disable iff (!presetn) // R06
    accept && cur_drop |=> !out_valid_r)
    else $error("frame from radio-looped port was forwarded");
  a_no_bubble: assert property (@(posedge pclk) disable iff (!presetn) // R10
    out_valid_r && !out_ready |=> out_valid_r && $stable(out_data_r))
    else $error("stalled beat lost or changed");
  c_frame_looped: cover property (@(posedge pclk) disable iff (!presetn) looped_r);
  c_frame_dropped: cover property (@(posedge pclk) disable iff (!presetn) accept && cur_drop);
endmodule

// ---- tdm_and_mac_swap_loopback.sv ----
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "loop_consts.svh"
module tdm_and_mac_swap_loopback #(
  parameter int N_TRIB = 8,
  parameter int HS_W = 16,
  parameter int DW = 256,
  parameter bit MODEM_UNIT = 1'b1,
  parameter logic [7:0] RADIO_PORT = 8'h00,
  parameter int TICKS_PER_SEC = `SEC_TICKS
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [N_TRIB-1:0] line_rx,
  output logic [N_TRIB-1:0] line_tx,
  input wire logic [N_TRIB-1:0] bus_rx,
  output logic [N_TRIB-1:0] bus_tx,
  output logic [N_TRIB-1:0] route_ais,
  input wire logic [HS_W-1:0] hs_rx,
  output logic [HS_W-1:0] hs_tx,
  input wire logic radio_loop_active,
  input wire logic lrl_req,
  input wire logic lrl_port_lan,
  input wire logic lrl_stop,
  output logic lrl_accept,
  output logic lrl_refuse,
  output logic lrl_active,
  output loop_pkg::sess_state_t sess_state,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic in_sop,
  input wire logic in_eop,
  input wire logic [DW-1:0] in_data,
  input wire logic [7:0] in_port,
  input wire logic [7:0] in_lkp_port,
  output logic out_valid,
  input wire logic out_ready,
  output logic out_sop,
  output logic out_eop,
  output logic out_loop,
  output logic [7:0] out_port,
  output logic [DW-1:0] out_data
);
  import loop_pkg::*;

  initial begin
    if (N_TRIB < 1 || N_TRIB > 16) $error("N_TRIB must be 1..16");
    if (HS_W < 1) $error("HS_W must be positive");
    if (TICKS_PER_SEC < 1) $error("TICKS_PER_SEC must be positive");
  end

  localparam logic [31:0] TICK_LAST = 32'(TICKS_PER_SEC - 1);

  // ==========================================================
  // Register state
  logic da_filt_r, da_filt_nxt;
  logic sa_filt_r, sa_filt_nxt;
  logic egr_lkp_r, egr_lkp_nxt;
  logic [7:0] in_port_r, in_port_nxt;
  logic [7:0] eg_port_r, eg_port_nxt;
  logic [11:0] vid_r, vid_nxt;
  logic [47:0] da_r, da_nxt;
  logic [47:0] sa_r, sa_nxt;
  logic [47:0] own_r, own_nxt;
  logic [15:0] timeout_r, timeout_nxt;
  logic [31:0] trib_loop_r, trib_loop_nxt;
  logic [N_TRIB-1:0] rx_loop_r, rx_loop_nxt;
  logic [N_TRIB-1:0] routed_r, routed_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic reject_r, reject_nxt;
  logic tmo_r, tmo_nxt;
  logic [31:0] looped_cnt_r, looped_cnt_nxt;
  logic start_req;
  logic stop_req;
  logic wr_en;
  logic rd_setup;
  logic addr_hit;
  logic [31:0] rd_val;
  // Session state
  sess_state_t state_r, state_nxt;
  logic [15:0] secs_r, secs_nxt;
  logic [31:0] tick_r, tick_nxt;
  logic sec_tick;
  logic expire;
  // Link remote loopback
  logic lrl_active_r, lrl_active_nxt;
  logic lrl_accept_r, lrl_accept_nxt;
  logic lrl_refuse_r, lrl_refuse_nxt;
  // Tributary paths
  logic [N_TRIB-1:0] line_tx_r, line_tx_nxt;
  logic [N_TRIB-1:0] bus_tx_r, bus_tx_nxt;
  logic [N_TRIB-1:0] route_ais_r, route_ais_nxt;
  logic [HS_W-1:0] hs_tx_r;

  swap_if sw ();

  // ==========================================================
  // APB decode and register next values
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  always_comb begin
    addr_hit = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (paddr)
      `REG_CTRL: rd_val = {27'h0, egr_lkp_r, sa_filt_r, da_filt_r, 2'b00};
      `REG_STATUS: rd_val = {28'h0, lrl_active_r, tmo_r, reject_r, state_r == SES_ACTIVE};
      `REG_PORTS: rd_val = {4'h0, vid_r, eg_port_r, in_port_r};
      `REG_DA_LO: rd_val = da_r[31:0];
      `REG_DA_HI: rd_val = {16'h0, da_r[47:32]};
      `REG_SA_LO: rd_val = sa_r[31:0];
      `REG_SA_HI: rd_val = {16'h0, sa_r[47:32]};
      `REG_OWN_LO: rd_val = own_r[31:0];
      `REG_OWN_HI: rd_val = {16'h0, own_r[47:32]};
      `REG_TIMEOUT: rd_val = {16'h0, timeout_r};
      `REG_REMAIN: rd_val = {16'h0, secs_r};
      `REG_TRIB_LOOP: rd_val = trib_loop_r;
      `REG_RX_LOOP: rd_val = 32'(rx_loop_r);
      `REG_ROUTED: rd_val = 32'(routed_r);
      `REG_LOOPED_CNT: rd_val = looped_cnt_r;
      default: addr_hit = 1'b0;
    endcase
  end

  always_comb begin
    da_filt_nxt = da_filt_r;
    sa_filt_nxt = sa_filt_r;
    egr_lkp_nxt = egr_lkp_r;
    in_port_nxt = in_port_r;
    eg_port_nxt = eg_port_r;
    vid_nxt = vid_r;
    da_nxt = da_r;
    sa_nxt = sa_r;
    own_nxt = own_r;
    timeout_nxt = timeout_r;
    trib_loop_nxt = trib_loop_r;
    rx_loop_nxt = rx_loop_r;
    routed_nxt = routed_r;
    prdata_nxt = rd_setup ? rd_val : prdata_r;
    start_req = 1'b0;
    stop_req = 1'b0;
    reject_nxt = reject_r;
    tmo_nxt = tmo_r;
    looped_cnt_nxt = looped_cnt_r + 32'(sw.looped);
    if (wr_en) begin
      unique case (paddr)
        `REG_CTRL: begin
          start_req = pwdata[`CTRL_START];
          stop_req = pwdata[`CTRL_STOP];
          da_filt_nxt = pwdata[`CTRL_DA_FILT];
          sa_filt_nxt = pwdata[`CTRL_SA_FILT];
          egr_lkp_nxt = pwdata[`CTRL_EGR_LKP];
        end
        `REG_STATUS: begin
          reject_nxt = reject_r && !pwdata[`ST_REJECT];
          tmo_nxt = tmo_r && !pwdata[`ST_TIMEOUT];
        end
        `REG_PORTS: begin
          in_port_nxt = pwdata[`PORTS_IN_LSB +: 8];
          eg_port_nxt = pwdata[`PORTS_EG_LSB +: 8];
          vid_nxt = pwdata[`PORTS_VID_LSB +: 12];
        end
        `REG_DA_LO: da_nxt[31:0] = pwdata;
        `REG_DA_HI: da_nxt[47:32] = pwdata[15:0];
        `REG_SA_LO: sa_nxt[31:0] = pwdata;
        `REG_SA_HI: sa_nxt[47:32] = pwdata[15:0];
        `REG_OWN_LO: own_nxt[31:0] = pwdata;
        `REG_OWN_HI: own_nxt[47:32] = pwdata[15:0];
        `REG_TIMEOUT: timeout_nxt = pwdata[15:0];
        `REG_TRIB_LOOP: trib_loop_nxt = pwdata; // R17
        `REG_RX_LOOP: rx_loop_nxt = pwdata[N_TRIB-1:0];
        `REG_ROUTED: routed_nxt = pwdata[N_TRIB-1:0];
        default: ;
      endcase
    end
    // Hardware set beats a software clear in the same cycle
    if (start_req && state_r == SES_ACTIVE) reject_nxt = 1'b1; // R14
    if (expire) tmo_nxt = 1'b1; // R15
  end

  // ==========================================================
  // Session timer next values
  assign sec_tick = (tick_r == TICK_LAST);
  assign expire = (state_r == SES_ACTIVE) && sec_tick && (secs_r <= 16'h0001) && !stop_req;
  always_comb begin
    state_nxt = state_r;
    secs_nxt = secs_r;
    tick_nxt = sec_tick ? 32'h0000_0000 : tick_r + 32'h0000_0001;
    unique case (state_r)
      SES_IDLE: begin
        if (start_req) begin
          state_nxt = SES_ACTIVE;
          secs_nxt = timeout_r;
          tick_nxt = 32'h0000_0000;
        end
      end
      SES_ACTIVE: begin
        if (stop_req || expire) begin // R15
          state_nxt = SES_IDLE;
          secs_nxt = 16'h0000;
        end else if (sec_tick) begin
          secs_nxt = secs_r - 16'h0001;
        end
      end
    endcase
  end

  // ==========================================================
  // Link remote loopback admission next values
  always_comb begin
    lrl_accept_nxt = lrl_req && lrl_port_lan; // R07
    lrl_refuse_nxt = lrl_req && !lrl_port_lan; // R07
    lrl_active_nxt = lrl_active_r;
    if (lrl_stop) lrl_active_nxt = 1'b0;
    if (lrl_req && lrl_port_lan) lrl_active_nxt = 1'b1;
  end

  // ==========================================================
  // Per-tributary loop paths
  generate
    for (genvar i = 0; i < N_TRIB; i++) begin : g_trib
      trib_loop_t mode;
      logic rxl;
      assign mode = trib_loop_t'(trib_loop_r[2*i +: 2]);
      assign rxl = MODEM_UNIT && rx_loop_r[i];
      always_comb begin
        line_tx_nxt[i] = bus_rx[i];
        bus_tx_nxt[i] = rxl ? bus_rx[i] : line_rx[i]; // R05
        route_ais_nxt[i] = 1'b0;
        unique case (mode)
          LOOP_NONE: ;
          LOOP_CONN: begin
            bus_tx_nxt[i] = bus_rx[i]; // R01
            route_ais_nxt[i] = routed_r[i]; // R02
          end
          LOOP_LINE: begin
            line_tx_nxt[i] = line_rx[i]; // R03
            bus_tx_nxt[i] = 1'b1; // R03 R16
          end
          LOOP_LOCAL: begin
            bus_tx_nxt[i] = bus_rx[i]; // R04
            line_tx_nxt[i] = 1'b1; // R04 R16
          end
        endcase
      end
      a_line_loop: assert property (@(posedge pclk) disable iff (!presetn) // R03
        mode == LOOP_LINE |=> bus_tx_r[i] && line_tx_r[i] == $past(line_rx[i]))
        else $error("line loop path or AIS wrong");
      a_local_loop: assert property (@(posedge pclk) disable iff (!presetn) // R04
        mode == LOOP_LOCAL |=> line_tx_r[i] && bus_tx_r[i] == $past(bus_rx[i]))
        else $error("local loop path or AIS wrong");
      a_conn_loop: assert property (@(posedge pclk) disable iff (!presetn) // R02
        mode == LOOP_CONN |=> bus_tx_r[i] == $past(bus_rx[i]) && route_ais_r[i] == $past(routed_r[i]))
        else $error("connection loop path or routed AIS wrong");
      a_ais_steady: assert property (@(posedge pclk) disable iff (!presetn) // R16
        mode == LOOP_LINE [*3] |=> bus_tx_r[i])
        else $error("line loop AIS not continuous");
    end
  endgenerate

  // ==========================================================
  // All registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {egr_lkp_r, sa_filt_r, da_filt_r} <= 3'(`CTRL_RST >> `CTRL_DA_FILT);
      in_port_r <= 8'h00;
      eg_port_r <= 8'h00;
      vid_r <= 12'h000;
      da_r <= 48'h0;
      sa_r <= 48'h0;
      own_r <= 48'h0;
      timeout_r <= `TIMEOUT_RST_S; // R15
      trib_loop_r <= 32'h0;
      rx_loop_r <= '0;
      routed_r <= '0;
      prdata_r <= 32'h0;
      reject_r <= 1'b0;
      tmo_r <= 1'b0;
      looped_cnt_r <= 32'h0;
      state_r <= SES_IDLE;
      secs_r <= 16'h0000;
      tick_r <= 32'h0;
      lrl_active_r <= 1'b0;
      lrl_accept_r <= 1'b0;
      lrl_refuse_r <= 1'b0;
      line_tx_r <= '1;
      bus_tx_r <= '1;
      route_ais_r <= '0;
      hs_tx_r <= '0;
    end else begin
      da_filt_r <= da_filt_nxt;
      sa_filt_r <= sa_filt_nxt;
      egr_lkp_r <= egr_lkp_nxt;
      in_port_r <= in_port_nxt;
      eg_port_r <= eg_port_nxt;
      vid_r <= vid_nxt;
      da_r <= da_nxt;
      sa_r <= sa_nxt;
      own_r <= own_nxt;
      timeout_r <= timeout_nxt;
      trib_loop_r <= trib_loop_nxt;
      rx_loop_r <= rx_loop_nxt;
      routed_r <= routed_nxt;
      prdata_r <= prdata_nxt;
      reject_r <= reject_nxt;
      tmo_r <= tmo_nxt;
      looped_cnt_r <= looped_cnt_nxt;
      state_r <= state_nxt;
      secs_r <= secs_nxt;
      tick_r <= tick_nxt;
      lrl_active_r <= lrl_active_nxt;
      lrl_accept_r <= lrl_accept_nxt;
      lrl_refuse_r <= lrl_refuse_nxt;
      line_tx_r <= line_tx_nxt;
      bus_tx_r <= bus_tx_nxt;
      route_ais_r <= route_ais_nxt;
      hs_tx_r <= hs_rx; // R05
    end
  end

  // ==========================================================
  // Outputs and swap configuration
  assign prdata = prdata_r;
  assign pready = psel && penable;
  assign pslverr = psel && penable && !addr_hit;
  assign line_tx = line_tx_r;
  assign bus_tx = bus_tx_r;
  assign route_ais = route_ais_r;
  assign hs_tx = hs_tx_r;
  assign lrl_accept = lrl_accept_r;
  assign lrl_refuse = lrl_refuse_r;
  assign lrl_active = lrl_active_r;
  assign sess_state = state_r;
  assign sw.active = (state_r == SES_ACTIVE); // R14
  assign sw.da_filt = da_filt_r;
  assign sw.sa_filt = sa_filt_r;
  assign sw.egr_lkp = egr_lkp_r;
  assign sw.in_port = in_port_r;
  assign sw.eg_port = eg_port_r;
  assign sw.vid = vid_r;
  assign sw.da = da_r;
  assign sw.sa = sa_r;
  assign sw.own_mac = own_r;
  assign sw.radio_loop = radio_loop_active;
  assign sw.radio_port = RADIO_PORT;

  mac_swap #(.DW(DW)) u_swap (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(sw.swapper),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_sop(in_sop),
    .in_eop(in_eop),
    .in_data(in_data),
    .in_port(in_port),
    .in_lkp_port(in_lkp_port),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_sop(out_sop),
    .out_eop(out_eop),
    .out_loop(out_loop),
    .out_port(out_port),
    .out_data(out_data)
  );

  // ==========================================================
  // Checks
  a_second_reject: assert property (@(posedge pclk) disable iff (!presetn) // R14
    start_req && state_r == SES_ACTIVE && !stop_req && !expire |=>
    reject_r && state_r == SES_ACTIVE)
    else $error("second session not rejected");
  a_timeout_end: assert property (@(posedge pclk) disable iff (!presetn) // R15
    expire |=> state_r == SES_IDLE && tmo_r)
    else $error("session did not end at timeout");
  a_lrl_admit: assert property (@(posedge pclk) disable iff (!presetn) // R07
    lrl_req && !lrl_port_lan && !lrl_active_r |=> lrl_refuse_r && !lrl_accept_r && !lrl_active_r)
    else $error("non-LAN remote loopback not refused");
  c_session_start: cover property (@(posedge pclk) disable iff (!presetn)
    state_r == SES_IDLE ##1 state_r == SES_ACTIVE);
  c_session_timeout: cover property (@(posedge pclk) disable iff (!presetn) expire);
  c_second_reject: cover property (@(posedge pclk) disable iff (!presetn)
    start_req && state_r == SES_ACTIVE);
endmodule

// ---- switch_model.sv ----
`timescale 1ns/10ps
// ==========================================
// Switch side: takes egress beats, promptly or with stalls
module switch_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic out_valid,
  output logic out_ready
);
  logic rdy_r;
  logic rdy_nxt;
  // Slow mode alternates ready
  always_comb begin
    rdy_nxt = slow ? ~rdy_r : 1'b1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rdy_r <= 1'b0;
    else rdy_r <= rdy_nxt;
  end
  assign out_ready = rdy_r;
endmodule

// ---- tb_tdm_and_mac_swap_loopback.sv ----
`timescale 1ns/10ps
`include "loop_consts.svh"
module tb_tdm_and_mac_swap_loopback;
  import loop_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0] paddr = 0, line_rx = 0, bus_rx = 0, line_tx, bus_tx, route_ais, out_port;
  logic [31:0] pwdata = 0, prdata, r;
  logic [15:0] hs_rx = 0, hs_tx;
  logic lrl_req = 0, lan = 0, lrl_accept, lrl_refuse, lrl_active, slow = 1, out_ready;
  logic in_valid = 0, in_ready, sop = 0, out_valid, out_sop, out_eop, out_loop, radio = 0;
  logic [255:0] in_data = 0, out_data;
  sess_state_t sess_state;
  int miscompares = 0, comparisons = 0, i;
  logic [7:0] ex_l [4] = '{8'hc3, 8'hc3, 8'h5a, 8'hff};
  logic [7:0] ex_b [4] = '{8'h5a, 8'hc3, 8'hff, 8'hc3};
  tdm_and_mac_swap_loopback #(.TICKS_PER_SEC(10), .RADIO_PORT(8'h01))
    tdm_and_mac_swap_loopback_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_rx(line_rx), .line_tx(line_tx), .bus_rx(bus_rx), .bus_tx(bus_tx),
    .route_ais(route_ais), .hs_rx(hs_rx), .hs_tx(hs_tx), .radio_loop_active(radio),
    .lrl_req(lrl_req), .lrl_port_lan(lan), .lrl_stop(1'b0), .lrl_accept(lrl_accept),
    .lrl_refuse(lrl_refuse), .lrl_active(lrl_active), .sess_state(sess_state),
    .in_valid(in_valid), .in_ready(in_ready), .in_sop(sop), .in_eop(sop),
    .in_data(in_data), .in_port(8'h01), .in_lkp_port(8'h00), .out_valid(out_valid),
    .out_ready(out_ready), .out_sop(out_sop), .out_eop(out_eop), .out_loop(out_loop),
    .out_port(out_port), .out_data(out_data));
  switch_model switch_model_inst (.pclk(pclk), .presetn(presetn), .slow(slow),
    .out_valid(out_valid), .out_ready(out_ready));
  // ==========================================
  // Clock, checks and APB master
  initial begin
    forever #10 pclk = ~pclk;
  end
  task print_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %0t saw %h want %h", $time, s, e);
    end
  endtask
  task wait_for(input logic c);
    if (c !== 1'b1) begin
      miscompares++;
      print_verdict();
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err);
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    wait_for(pready);
    r = prdata;
    chk(pslverr, err);
    psel <= 0; penable <= 0;
  endtask
  task lrl(input logic l, input logic acc);
    @(posedge pclk);
    lrl_req <= 1; lan <= l;
    @(posedge pclk);
    lrl_req <= 0;
    #1 chk({lrl_accept, lrl_refuse, lrl_active}, {acc, ~acc, acc});
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, `REG_TIMEOUT, 0, 0);
    chk(r, 32'h0000012c);
    apb(0, 8'hfc, 0, 1);
    // Every tributary mode, each replacing the last
    line_rx <= 8'h5a; bus_rx <= 8'hc3; hs_rx <= 16'ha5c3;
    apb(1, `REG_ROUTED, 32'h0000000f, 0);
    for (int m = 0; m < 4; m++) begin
      apb(1, `REG_TRIB_LOOP, {16'h0000, {8{m[1:0]}}}, 0);
      repeat (3) @(posedge pclk);
      #1 chk({line_tx, bus_tx}, {ex_l[m], ex_b[m]});
      chk(route_ais, (m == 1) ? 8'h0f : 8'h00);
      chk(hs_tx, 16'ha5c3);
    end
    // Modem receive loop on the low four tributaries
    apb(1, `REG_TRIB_LOOP, 0, 0);
    apb(1, `REG_RX_LOOP, 32'h0000000f, 0);
    repeat (3) @(posedge pclk);
    #1 chk(bus_tx, 8'h53);
    $display("test trib done");
    lrl(0, 0);
    lrl(1, 1);
    $display("test lrl done");
    // Swap session, own MAC replaces source with no DA filter
    apb(1, `REG_PORTS, 32'h00050001, 0);
    apb(1, `REG_OWN_LO, 32'h0000beef, 0);
    apb(1, `REG_OWN_HI, 32'h00000a0b, 0);
    apb(1, `REG_TIMEOUT, 32'h00000008, 0);
    apb(1, `REG_CTRL, 32'h00000011, 0);
    #1 chk(sess_state, SES_ACTIVE);
    apb(1, `REG_CTRL, 32'h00000011, 0);
    apb(0, `REG_STATUS, 0, 0);
    chk(r[1:0], 2'b11);
    @(posedge pclk);
    in_valid <= 1; sop <= 1;
    in_data <= {48'h111111111111, 48'h222222222222, 32'h81000005, 128'h0};
    for (i = 0; i < 20 && !(in_valid && in_ready === 1'b1); i++) @(posedge pclk);
    in_valid <= 0;
    for (i = 0; i < 20 && out_valid !== 1'b1; i++) @(posedge pclk);
    wait_for(out_valid);
    chk({out_loop, out_sop, out_eop, out_port}, {3'b111, 8'h01});
    chk(out_data[255-:32], 32'h22222222);
    chk(out_data[207:176], 32'h0a0b0000);
    // Frame from the radio-looped port is discarded and not counted
    radio <= 1;
    @(posedge pclk);
    in_valid <= 1;
    for (i = 0; i < 20 && !(in_valid && in_ready === 1'b1); i++) @(posedge pclk);
    in_valid <= 0;
    @(posedge pclk);
    chk(out_valid, 0);
    apb(0, `REG_LOOPED_CNT, 0, 0);
    chk(r, 32'h00000001);
    $display("test swap done");
    for (i = 0; i < 200 && sess_state !== SES_IDLE; i++) @(posedge pclk);
    wait_for(sess_state === SES_IDLE);
    apb(0, `REG_STATUS, 0, 0);
    chk(r[2:0], 3'b110);
    $display("test timeout done");
    print_verdict();
  end
endmodule
